// ===== tb/rac_check_props.sv
`timescale 1ns/10ps
// verdict timing, exclusivity and interrupt causes at the top ports
module rac_check_props
  import rac_pkg::*;
#(
  parameter int NREG = 8
)
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic        acc_write,
  input wire logic        acc_fetch,
  input wire logic        acc_priv,
  input wire logic        acc_done,
  input wire logic        acc_allow,
  input wire logic        perm_fault,
  input wire logic        fetch_error,
  input wire logic        severe_fault_exception,
  input rac_pkg::rac_mem_t acc_mem_type,
  input wire logic        acc_shareable,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // one verdict per request, exactly one cycle later
  property p_done_next; acc_valid |=> acc_done; endproperty
  a_done_next: assert property (p_done_next) else $error("done missing after request");
  property p_quiet; !acc_valid |=> !(acc_done || acc_allow || perm_fault || fetch_error || severe_fault_exception);
  endproperty
  a_quiet: assert property (p_quiet) else $error("verdict without request");
  property p_one_verdict; acc_done |-> $onehot({acc_allow, perm_fault, fetch_error}); endproperty
  a_one_verdict: assert property (p_one_verdict) else $error("verdict not exclusive");
  property p_fetch_sev; acc_done |-> (fetch_error == severe_fault_exception); endproperty
  a_fetch_sev: assert property (p_fetch_sev) else $error("severe fault not paired with fetch error");
  property p_data_no_fetch_err; acc_valid && !acc_fetch |=> !fetch_error; endproperty
  a_data_no_fetch_err: assert property (p_data_no_fetch_err) else $error("fetch error on data access");
  property p_fetch_no_perm; acc_valid && acc_fetch |=> !perm_fault; endproperty
  a_fetch_no_perm: assert property (p_fetch_no_perm) else $error("data fault on fetch");
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  // irq only moves after an access verdict or a register write
  property p_irq_rise; $rose(irq) |-> $past(acc_done) || $past(reg_wr, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall; $fell(irq) && !$past(rst) |-> $past(reg_wr, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  c_fetch_err: cover property (fetch_error);
  c_perm_fault: cover property (perm_fault);
  c_irq: cover property ($rose(irq));
endmodule // rac_check_props

// ===== tb/rac_core_model.sv
`timescale 1ns/10ps
// core side: issues one access and captures the verdict
module rac_core_model
(
  input  wire logic        mclk,
  output logic             acc_valid,
  output logic [31:0]      acc_addr,
  output logic             acc_write,
  output logic             acc_fetch,
  output logic             acc_priv,
  input  wire logic        acc_done,
  input  wire logic        acc_allow,
  input  wire logic        perm_fault,
  input  wire logic        fetch_error,
  input  wire logic        severe_fault_exception
);
  initial
  begin
    acc_valid = 1'b0;
    acc_addr  = 32'h0000_0000;
    acc_write = 1'b0;
    acc_fetch = 1'b0;
    acc_priv  = 1'b0;
  end
  // released qualifiers show inverted values so a stale request never passes
  task automatic issue(input logic [31:0] a, input logic w, input logic f, input logic p, output logic [31:0] v);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_addr  <= a;
    acc_write <= w;
    acc_fetch <= f;
    acc_priv  <= p;
    @(posedge mclk);
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_write <= ~w;
    acc_fetch <= ~f;
    acc_priv  <= ~p;
    @(negedge mclk);
    v = {27'h0, acc_done, acc_allow, perm_fault, fetch_error, severe_fault_exception};
  endtask
endmodule // rac_core_model

// ===== tb/test_region_attribute_check.sv
`timescale 1ns/10ps
module test_region_attribute_check;
  import rac_pkg::*;
  localparam int NREG = 8;
  logic              mclk;
  logic              rst;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              acc_valid;
  logic [31:0]       acc_addr;
  logic              acc_write;
  logic              acc_fetch;
  logic              acc_priv;
  logic              acc_done;
  logic              acc_allow;
  logic              perm_fault;
  logic              fetch_error;
  logic              severe_fault_exception;
  rac_mem_t          acc_mem_type;
  logic              acc_shareable;
  logic              irq;
  logic [31:0]       v;
  int                n_mismatch;
  int                samples_checked;

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  rac_check #(.NREG(NREG)) rac_check_i (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .acc_valid, .acc_addr, .acc_write, .acc_fetch, .acc_priv, .acc_done, .acc_allow, .perm_fault,
    .fetch_error, .severe_fault_exception, .acc_mem_type, .acc_shareable, .irq);
  rac_core_model rac_core_model_i (.mclk, .acc_valid, .acc_addr, .acc_write, .acc_fetch, .acc_priv,
    .acc_done, .acc_allow, .perm_fault, .fetch_error, .severe_fault_exception);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge mclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // allowed {read, write} per permission code and privilege
  function automatic logic [1:0] perm(input logic [2:0] ap, input logic p);
    case (ap)
      3'h1: return p ? 2'h3 : 2'h0;
      3'h2: return p ? 2'h3 : 2'h2;
      3'h3: return 2'h3;
      3'h5: return p ? 2'h2 : 2'h0;
      3'h6, 3'h7: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction

  task automatic t_reset;
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_STATUS, 32'h0000_0000);
    rd(OFS_MASK, MASK_RST);
    rd(OFS_RATTR0, ATTR_RST);
    rd(8'hFC, 32'h0000_0000);
    irq_is(1'b0);
  endtask
  // every permission code, no-execute value, access kind and privilege
  task automatic t_perm;
    logic       ok;
    logic [1:0] pm;
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_RBASE0, 32'h0000_1000);
    for (int ap = 0; ap < 8; ap++)
      for (int xn = 0; xn < 2; xn++)
      begin
        wr(OFS_RATTR0, {3'h0, xn[0], 1'b0, ap[2:0], 24'h03_000F});
        for (int k = 0; k < 3; k++)
          for (int p = 0; p < 2; p++)
          begin
            pm = perm(ap[2:0], p[0]);
            ok = (k == 2) ? pm[1] && (xn == 0) : pm[k == 1 ? 0 : 1];
            rac_core_model_i.issue(32'h0000_1040, k == 1, k == 2, p[0], v);
            chk("verdict", {27'h0, 1'b1, ok, !ok && k != 2, !ok && k == 2, !ok && k == 2}, v);
          end
      end
  endtask
  // memory type for type-ext 000 and 001, shareability for 000 only, with all cache, buffer, share settings
  task automatic t_type;
    rac_mem_t te;
    wr(OFS_STATUS, 32'h0000_0007);
    for (int i = 0; i < 16; i++)
    begin
      wr(OFS_RATTR0, 32'h0300_000F | {i[3] ? 3'h1 : 3'h0, i[2:0], 16'h0});
      te = i[3] ? RAC_MEM_RESERVED : (i[1] ? (i[0] ? RAC_MEM_NORMAL_WB : RAC_MEM_NORMAL_WT) :
        (i[0] ? RAC_MEM_DEVICE : RAC_MEM_STRONG));
      rac_core_model_i.issue(32'h0000_10FC, 1'b0, 1'b0, 1'b1, v);
      chk("acc_mem_type", 32'(te), 32'(acc_mem_type));
      if (i < 8)
        chk("acc_shareable", {31'h0, i[1] ? i[2] : 1'b1}, {31'h0, acc_shareable});
    end
    rd(OFS_STATUS, 32'h0000_0004);
  endtask
  // enables, region miss and overlap priority
  task automatic t_enable;
    wr(OFS_RATTR0, 32'h0000_000F);
    wr(OFS_CTRL, 32'h0000_0000);
    rac_core_model_i.issue(32'h0000_1000, 1'b0, 1'b0, 1'b1, v);
    chk("verdict", 32'h18, v);
    chk("acc_mem_type", 32'(RAC_MEM_NORMAL_WB), 32'(acc_mem_type));
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_RATTR0, 32'h0003_000E);
    rac_core_model_i.issue(32'h0000_1000, 1'b0, 1'b0, 1'b1, v);
    chk("verdict", 32'h18, v);
    wr(OFS_RATTR0, 32'h0003_000F);
    rac_core_model_i.issue(32'h0000_1100, 1'b1, 1'b0, 1'b0, v);
    chk("verdict", 32'h18, v);
    wr(OFS_RBASE0 + 8'h08, 32'h0000_1000);
    wr(OFS_RATTR0 + 8'h08, 32'h0303_000F);
    rac_core_model_i.issue(32'h0000_1000, 1'b0, 1'b0, 1'b1, v);
    chk("verdict", 32'h18, v);
    wr(OFS_RATTR0 + 8'h08, 32'h0000_0000);
  endtask
  // sticky status, mask and one-to-clear
  task automatic t_irq;
    wr(OFS_STATUS, 32'h0000_0007);
    wr(OFS_MASK, 32'h0000_0001);
    rac_core_model_i.issue(32'h0000_1044, 1'b0, 1'b0, 1'b0, v);
    chk("verdict", 32'h14, v);
    irq_is(1'b1);
    rd(OFS_LASTFLT, 32'h0000_1044);
    wr(OFS_MASK, 32'h0000_0000);
    irq_is(1'b0);
    wr(OFS_MASK, 32'h0000_0001);
    irq_is(1'b1);
    wr(OFS_STATUS, 32'h0000_0001);
    irq_is(1'b0);
    rd(OFS_STATUS, 32'h0000_0000);
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bound well above the expected run of a few hundred cycles
  initial
  begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    n_mismatch      = 0;
    samples_checked = 0;
    rst       = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_perm();
    t_type();
    t_enable();
    t_irq();
    tally_and_finish();
  end
endmodule // test_region_attribute_check

bind rac_check rac_check_props #(.NREG(NREG)) rac_check_props_i (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .acc_valid, .acc_addr, .acc_write, .acc_fetch, .acc_priv, .acc_done, .acc_allow,
  .perm_fault, .fetch_error, .severe_fault_exception, .acc_mem_type, .acc_shareable, .irq);

// ===== verilog/rac_check.sv
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Behaviour
// RQ1: type-ext 000, C0 B0 strongly-ordered shareable; C0 B1 shared device.
// RQ2: type-ext 000, C1 B0: normal, write-through, no write allocate.
// RQ3: type-ext 000, C1 B1: normal, write-back, no write allocate.
// RQ4: software programs only the four defined type combinations.
// RQ5: normal memory shareable exactly when share flag is one.
// RQ6: strongly-ordered and device ignore the share flag.
// RQ7: permission 000 denies all access and faults.
// RQ8: permission 010: privileged read-write, unprivileged read-only, unprivileged write faults.
// RQ9: permission 110 or 111: read-only for both levels.
// RQ10: 001 privileged-only, 011 full, 101 privileged read-only; 100 reserved.
// RQ11: no-execute flag one forbids fetching and executing.
// RQ12: no-execute flag zero permits fetch, subject to permissions.
// RQ13: execute needs read access at current privilege and clear no-execute.
// RQ14: bad fetch flags error and raises severe fault before execution.
// RQ15: field positions: no-exec 28, perm 26:24, type-ext 21:19, S/C/B 18..16.
// RQ16: attributes apply only with region enable and global enable both set.
// RQ17: access checked against hit region using requester privilege.
module rac_check
  import rac_pkg::*;
#(
  parameter int NREG = 8
)
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  input  wire logic                 acc_valid,
  input  wire logic [31:0]          acc_addr,
  input  wire logic                 acc_write,
  input  wire logic                 acc_fetch,
  input  wire logic                 acc_priv,
  output logic                      acc_done,
  output logic                      acc_allow,
  output logic                      perm_fault,
  output logic                      fetch_error,
  output logic                      severe_fault_exception,
  output rac_pkg::rac_mem_t         acc_mem_type,
  output logic                      acc_shareable,
  output logic                      irq
);
  localparam int IW = $clog2(NREG);

  logic [31:0]      base_q [NREG];
  logic [31:0]      attr_q [NREG];
  logic             protection_unit_global_enable;
  logic [2:0]       status_q;
  logic [2:0]       mask_q;
  logic [31:0]      lastflt_q;
  logic [NREG-1:0]  hit_v;
  logic [NREG-1:0]  rd_v;
  logic [NREG-1:0]  wr_v;
  logic [NREG-1:0]  xn_v;
  logic [NREG-1:0]  sh_v;
  rac_mem_t         mt_v [NREG];
  logic             sel_hit;
  logic [IW-1:0]    sel_idx;
  logic             ok_d;
  logic             pf_d;
  logic             fe_d;
  logic             rsvd_d;
  rac_mem_t         mt_d;
  logic             sh_d;
  logic [2:0]       ev_d;
  logic             ctrl_wr;
  logic             mask_wr;
  logic             status_wr;

  // index of a region register word, or -1 if not one
  function automatic int region_word(input logic [7:0] a, input logic attr_word);
    int r;
    r = -1;
    for (int i = 0; i < NREG; i++)
    begin
      if (a == OFS_RBASE0 + 8'(i * 8) + (attr_word ? 8'h04 : 8'h00))
      begin
        r = i;
      end
    end
    return r;
  endfunction

  // per-region decoders
  generate
    for (genvar g = 0; g < NREG; g++)
    begin : g_reg
      rac_decode u_dec (
        .addr            (acc_addr),
        .base            (base_q[g]),
        .attr            (attr_q[g]),
        .priv            (acc_priv), // RQ17
        .mem_type        (mt_v[g]),
        .shareable       (sh_v[g]),
        .hit             (hit_v[g]),
        .rd_ok           (rd_v[g]),
        .wr_ok           (wr_v[g]),
        .no_execute_flag (xn_v[g])
      );
    end
  endgenerate

  // highest numbered hitting region wins on overlap
  always_comb
  begin
    sel_hit = 1'b0;
    sel_idx = '0;
    for (int i = 0; i < NREG; i++)
    begin
      if (hit_v[i])
      begin
        sel_hit = 1'b1;
        sel_idx = IW'(i);
      end
    end
  end

  // verdict; with unit off or no hit, access passes unchecked as normal memory
  always_comb
  begin
    ok_d   = 1'b1;
    pf_d   = 1'b0;
    fe_d   = 1'b0;
    rsvd_d = 1'b0;
    mt_d   = RAC_MEM_NORMAL_WB;
    sh_d   = 1'b0;
    if (protection_unit_global_enable && sel_hit) // RQ16
    begin
      mt_d   = mt_v[sel_idx];
      sh_d   = sh_v[sel_idx];
      rsvd_d = (mt_v[sel_idx] == RAC_MEM_RESERVED); // RQ4
      if (acc_fetch)
      begin
        ok_d = rd_v[sel_idx] && !xn_v[sel_idx]; // RQ11 RQ12 RQ13
        fe_d = !ok_d; // RQ14
      end
      else if (acc_write)
      begin
        ok_d = wr_v[sel_idx]; // RQ7 RQ8 RQ9
        pf_d = !ok_d;
      end
      else
      begin
        ok_d = rd_v[sel_idx]; // RQ7 RQ10
        pf_d = !ok_d;
      end
    end
  end

  assign ev_d = acc_valid ? {rsvd_d, fe_d, pf_d} : 3'h0;

  // registered verdict, one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_done               <= 1'b0;
      acc_allow              <= 1'b0;
      perm_fault             <= 1'b0;
      fetch_error            <= 1'b0;
      severe_fault_exception <= 1'b0;
    end
    else
    begin
      acc_done               <= acc_valid;
      acc_allow              <= acc_valid && ok_d;
      perm_fault             <= ev_d[ST_PERM]; // RQ7 RQ8 RQ9
      fetch_error            <= ev_d[ST_FETCH]; // RQ14
      severe_fault_exception <= ev_d[ST_FETCH]; // RQ14
    end
  end

  // attributes follow the address every cycle; only meaningful beside acc_done
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_mem_type  <= RAC_MEM_STRONG;
      acc_shareable <= 1'b0;
    end
    else
    begin
      acc_mem_type  <= mt_d; // RQ1 RQ2 RQ3
      acc_shareable <= sh_d; // RQ5 RQ6
    end
  end

  // write strobes of the single-word registers, decoded once
  assign ctrl_wr   = reg_wr && (reg_addr == OFS_CTRL);
  assign mask_wr   = reg_wr && (reg_addr == OFS_MASK);
  assign status_wr = reg_wr && (reg_addr == OFS_STATUS);

  // region base words; low byte is not stored and reads as zero
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        base_q[i] <= 32'h0000_0000;
      end
    end
    else if (reg_wr)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        if (region_word(reg_addr, 1'b0) == i)
        begin
          base_q[i] <= {reg_wdata[31:8], 8'h00};
        end
      end
    end
  end

  // region attribute words; a new word governs accesses from the next edge on
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        attr_q[i] <= ATTR_RST;
      end
    end
    else if (reg_wr)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        if (region_word(reg_addr, 1'b1) == i)
        begin
          attr_q[i] <= reg_wdata; // RQ15
        end
      end
    end
  end

  // global enable; off after reset so nothing faults before software sets up regions
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      protection_unit_global_enable <= CTRL_RST[0];
    end
    else if (ctrl_wr)
    begin
      protection_unit_global_enable <= reg_wdata[0]; // RQ16
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mask_q <= MASK_RST[2:0];
    end
    else if (mask_wr)
    begin
      mask_q <= reg_wdata[2:0];
    end
  end

  // sticky status: set beats a simultaneous write-one clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      status_q <= 3'h0;
    end
    else
    begin
      status_q <= (status_q & ~(status_wr ? reg_wdata[2:0] : 3'h0)) | ev_d;
    end
  end

  // address of the most recent faulting access
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      lastflt_q <= 32'h0000_0000;
    end
    else if (acc_valid && (fe_d || pf_d))
    begin
      lastflt_q <= acc_addr;
    end
  end

  // level interrupt from a flop; lags status by one cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_q & mask_q);
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h0000_0000;
    end
    else if (reg_rd)
    begin
      reg_rdata <= 32'h0000_0000;
      if (reg_addr == OFS_CTRL)
      begin
        reg_rdata <= {31'h0, protection_unit_global_enable};
      end
      if (reg_addr == OFS_STATUS)
      begin
        reg_rdata <= {29'h0, status_q};
      end
      if (reg_addr == OFS_MASK)
      begin
        reg_rdata <= {29'h0, mask_q};
      end
      if (reg_addr == OFS_LASTFLT)
      begin
        reg_rdata <= lastflt_q;
      end
      for (int i = 0; i < NREG; i++)
      begin
        if (region_word(reg_addr, 1'b0) == i)
        begin
          reg_rdata <= base_q[i];
        end
        if (region_word(reg_addr, 1'b1) == i)
        begin
          reg_rdata <= attr_q[i];
        end
      end
    end
    else
    begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // rac_check

// ===== verilog/rac_decode.sv
`timescale 1ns/10ps
// one region: hit test plus attribute decode
module rac_decode
  import rac_pkg::*;
(
  input  wire logic [31:0]    addr,
  input  wire logic [31:0]    base,
  input  wire logic [31:0]    attr,
  input  wire logic           priv,
  output rac_pkg::rac_mem_t   mem_type,
  output logic                shareable,
  output logic                hit,
  output logic                rd_ok,
  output logic                wr_ok,
  output logic                no_execute_flag
);
  logic [2:0] permission_code;
  logic [2:0] memory_type_ext_bits;
  logic [4:0] sz;
  logic [31:0] span_mask;

  // field extraction
  assign no_execute_flag      = attr[NO_EXEC_POS]; // RQ15
  assign permission_code      = attr[PERM_HI:PERM_LO]; // RQ15
  assign memory_type_ext_bits = attr[TYPE_EXT_HI:TYPE_EXT_LO]; // RQ15
  assign sz                   = attr[SIZE_HI:SIZE_LO];

  // region covers 2^(size+1) bytes; size 31 spans all
  always_comb
  begin
    span_mask = (sz == 5'h1F) ? 32'hFFFF_FFFF : ((32'h0000_0002 << sz) - 32'h0000_0001);
    hit = attr[REGION_EN_POS] && ((addr & ~span_mask) == (base & ~span_mask)); // RQ17
  end

  // memory type and shareability
  always_comb
  begin
    mem_type  = RAC_MEM_RESERVED;
    shareable = 1'b0;
    if (memory_type_ext_bits == TYPE_EXT_ZERO)
    begin
      case ({attr[CACHE_POS], attr[BUFFER_POS]})
        2'h0:
        begin
          mem_type  = RAC_MEM_STRONG; // RQ1
          shareable = 1'b1; // RQ6
        end
        2'h1:
        begin
          mem_type  = RAC_MEM_DEVICE; // RQ1
          shareable = 1'b1; // RQ6
        end
        2'h2:
        begin
          mem_type  = RAC_MEM_NORMAL_WT; // RQ2
          shareable = attr[SHARE_POS]; // RQ5
        end
        default:
        begin
          mem_type  = RAC_MEM_NORMAL_WB; // RQ3
          shareable = attr[SHARE_POS]; // RQ5
        end
      endcase
    end
  end

  // permission table; reserved code 100 treated as no access
  always_comb
  begin
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    case (permission_code)
      3'h0:
      begin
        rd_ok = 1'b0; // RQ7
        wr_ok = 1'b0;
      end
      3'h1:
      begin
        rd_ok = priv; // RQ10
        wr_ok = priv;
      end
      3'h2:
      begin
        rd_ok = 1'b1; // RQ8
        wr_ok = priv;
      end
      3'h3:
      begin
        rd_ok = 1'b1; // RQ10
        wr_ok = 1'b1;
      end
      3'h5:
      begin
        rd_ok = priv; // RQ10
        wr_ok = 1'b0;
      end
      3'h6, 3'h7:
      begin
        rd_ok = 1'b1; // RQ9
        wr_ok = 1'b0;
      end
      default:
      begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
      end
    endcase
  end
endmodule // rac_decode

// ===== verilog/rac_pkg.sv
package rac_pkg;
  // region attribute word field positions
  localparam int NO_EXEC_POS   = 28;
  localparam int PERM_HI       = 26;
  localparam int PERM_LO       = 24;
  localparam int TYPE_EXT_HI   = 21;
  localparam int TYPE_EXT_LO   = 19;
  localparam int SHARE_POS     = 18;
  localparam int CACHE_POS     = 17;
  localparam int BUFFER_POS    = 16;
  localparam int SIZE_HI       = 5;
  localparam int SIZE_LO       = 1;
  localparam int REGION_EN_POS = 0;

  // register offsets, 32-bit words at byte addresses
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_MASK    = 8'h08;
  localparam logic [7:0] OFS_RBASE0  = 8'h10;
  localparam logic [7:0] OFS_RATTR0  = 8'h14;
  localparam logic [7:0] OFS_LASTFLT = 8'h0C; // kept clear of the region words, which reach 0x4C

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] ATTR_RST = 32'h0000_0000;

  // status bit positions
  localparam int ST_PERM  = 0;
  localparam int ST_FETCH = 1;
  localparam int ST_RSVD  = 2;

  localparam logic [2:0] TYPE_EXT_ZERO = 3'h0;

  typedef enum logic [2:0] {
    RAC_MEM_STRONG,
    RAC_MEM_DEVICE,
    RAC_MEM_NORMAL_WT,
    RAC_MEM_NORMAL_WB,
    RAC_MEM_RESERVED
  } rac_mem_t;
endpackage
